// [design/afecr_config_regs.sv]
// front-end configuration bank at addresses 0 to 3 with a serial-command byte port
`timescale 1ns/1ps
module afecr_config_regs (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       resetn,
  // serial command byte stream (already deserialised, same clock)
  input  wire logic       cmdValid,
  input  wire logic [7:0] cmdByte,
  output logic            rspValid,
  output logic      [7:0] rspByte,
  // clock source status pin
  input  wire logic       extClockActive,
  // analog control outputs
  output logic      [1:0] burnoutCurrentSelect,
  output logic            biasNegative,
  output logic            biasPositive,
  output logic            monShortMid,
  output logic            monReference,
  output logic            monTemperature,
  output logic      [2:0] amplifierGain,
  output logic      [3:0] outputRateSelect
);

  // ==========================================================================
  // command sequencer
  typedef enum logic [1:0] {S_IDLE, S_COUNT, S_READ, S_WRITE} afecr_state_t;

  afecr_state_t state_r, state_nxt;
  logic [3:0]   addr_r, addr_nxt;
  logic [3:0]   left_r, left_nxt;
  logic         isWrite_r, isWrite_nxt;

  logic [1:0] burnSel_r;
  logic [1:0] biasEn_r;
  logic [2:0] monSel_r;
  logic [2:0] gain_r;
  logic [3:0] rate_r;
  logic [2:0] clkSync_r;
  logic       clkFlag_r;

  // addresses beyond the bank wrap back to the first register
  function automatic logic [3:0] nextAddr(input logic [3:0] a);
    nextAddr = (a >= afecr_pkg::LAST_REG) ? afecr_pkg::OFS_BURNOUT : 4'(a + 4'h1);
  endfunction : nextAddr

  wire logic opRead   = cmdValid && state_r == S_IDLE && cmdByte[7:4] == afecr_pkg::OPC_READ;
  wire logic opWrite  = cmdValid && state_r == S_IDLE && cmdByte[7:4] == afecr_pkg::OPC_WRITE;
  wire logic dataWr   = cmdValid && state_r == S_WRITE;
  wire logic dataRd   = cmdValid && state_r == S_READ;
  wire logic lastByte = left_r == 4'h0;

  always_comb begin
    state_nxt   = state_r;
    addr_nxt    = addr_r;
    left_nxt    = left_r;
    isWrite_nxt = isWrite_r;
    if (cmdValid) begin
      unique case (state_r)
        S_IDLE: begin
          if (opRead || opWrite) begin
            addr_nxt    = cmdByte[3:0];
            isWrite_nxt = opWrite;
            state_nxt   = S_COUNT;
          end
        end
        S_COUNT: begin
          left_nxt  = cmdByte[3:0];
          state_nxt = isWrite_r ? S_WRITE : S_READ;
        end
        // bytes sent during read-back are ignored, whatever they hold
        S_READ, S_WRITE: begin
          addr_nxt  = nextAddr(addr_r);
          left_nxt  = 4'(left_r - 4'h1);
          state_nxt = lastByte ? S_IDLE : state_r;
        end
      endcase
    end
  end

  // ==========================================================================
  // register read-back view
  wire logic [7:0] rdBurn = {burnSel_r, afecr_pkg::BURNOUT_LOW_RO};
  wire logic [7:0] rdBias = {afecr_pkg::BIAS_HIGH_RO, biasEn_r};
  wire logic [7:0] rdMon  = {clkFlag_r, afecr_pkg::MON_MID_RO, monSel_r};
  wire logic [7:0] rdSys  = {1'b0, gain_r, rate_r};

  // unimplemented addresses read as zero
  wire logic [7:0] rdMux =
      (addr_r == afecr_pkg::OFS_BURNOUT)  ? rdBurn :
      (addr_r == afecr_pkg::OFS_BIAS)     ? rdBias :
      (addr_r == afecr_pkg::OFS_MONITOR)  ? rdMon  :
      (addr_r == afecr_pkg::OFS_GAINRATE) ? rdSys  : 8'h00;

  // ==========================================================================
  // analog steering decode
  wire logic monActive = monSel_r != afecr_pkg::MON_NORMAL;
  wire logic forceUnity = monSel_r == afecr_pkg::MON_REFGAIN ||
                          monSel_r == afecr_pkg::MON_TEMP;
  wire logic [2:0] gainNxt = forceUnity ? afecr_pkg::GAIN_UNITY : gain_r;

  // ==========================================================================
  // state and registers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_r   <= S_IDLE;
      addr_r    <= 4'h0;
      left_r    <= 4'h0;
      isWrite_r <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      addr_r    <= addr_nxt;
      left_r    <= left_nxt;
      isWrite_r <= isWrite_nxt;
    end
  end

  // only the writable fields are stored, so writes cannot change the read-only bits
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      burnSel_r <= afecr_pkg::RST_BURNOUT_SEL;
      biasEn_r  <= afecr_pkg::RST_BIAS_EN;
      monSel_r  <= afecr_pkg::RST_MON_SEL;
      gain_r    <= afecr_pkg::RST_GAIN;
      rate_r    <= afecr_pkg::RST_RATE;
    end else if (dataWr) begin
      if (addr_r == afecr_pkg::OFS_BURNOUT)  burnSel_r <= cmdByte[7:6];
      if (addr_r == afecr_pkg::OFS_BIAS)     biasEn_r  <= cmdByte[1:0];
      if (addr_r == afecr_pkg::OFS_MONITOR)  monSel_r  <= cmdByte[2:0];
      if (addr_r == afecr_pkg::OFS_GAINRATE) begin
        gain_r <= cmdByte[6:4];
        rate_r <= cmdByte[3:0];
      end
    end
  end

  // clock-source pin is asynchronous: three stages, change taken when the last two agree
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      clkSync_r <= 3'h0;
      clkFlag_r <= 1'b0;
    end else begin
      clkSync_r <= {clkSync_r[1:0], extClockActive};
      if (clkSync_r[2] == clkSync_r[1]) clkFlag_r <= clkSync_r[2];
    end
  end

  // outputs
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rspValid             <= 1'b0;
      rspByte              <= 8'h00;
      burnoutCurrentSelect <= afecr_pkg::RST_BURNOUT_SEL;
      biasNegative         <= 1'b0;
      biasPositive         <= 1'b0;
      monShortMid          <= 1'b0;
      monReference         <= 1'b0;
      monTemperature       <= 1'b0;
      amplifierGain        <= afecr_pkg::RST_GAIN;
      outputRateSelect     <= afecr_pkg::RST_RATE;
    end else begin
      rspValid             <= dataRd;
      rspByte              <= dataRd ? rdMux : 8'h00;
      burnoutCurrentSelect <= burnSel_r;
      biasNegative         <= biasEn_r[1] && !monActive;
      biasPositive         <= biasEn_r[0] && !monActive;
      monShortMid          <= monSel_r == afecr_pkg::MON_OFFSET;
      monReference         <= monSel_r == afecr_pkg::MON_REFGAIN;
      monTemperature       <= monSel_r == afecr_pkg::MON_TEMP;
      amplifierGain        <= gainNxt;
      outputRateSelect     <= rate_r;
    end
  end

  // ==========================================================================
  // checks
  property p_bias_override;
    @(posedge core_clk) disable iff (!resetn)
    (monSel_r != afecr_pkg::MON_NORMAL) |=> !biasNegative && !biasPositive;
  endproperty
  a_bias_override: assert property (p_bias_override) else $error("bias not overridden");

  property p_unity_gain;
    @(posedge core_clk) disable iff (!resetn)
    forceUnity |=> amplifierGain == afecr_pkg::GAIN_UNITY;
  endproperty
  a_unity_gain: assert property (p_unity_gain) else $error("gain not forced to unity");

  property p_gain_revert;
    @(posedge core_clk) disable iff (!resetn)
    !forceUnity |=> amplifierGain == $past(gain_r);
  endproperty
  a_gain_revert: assert property (p_gain_revert) else $error("gain did not revert");

  sequence s_read_cmd;
    opRead ##1 (cmdValid && state_r == S_COUNT);
  endsequence
  property p_read_reply;
    @(posedge core_clk) disable iff (!resetn)
    s_read_cmd ##1 dataRd |=> rspValid;
  endproperty
  a_read_reply: assert property (p_read_reply) else $error("no read reply");

  property p_burn_low;
    @(posedge core_clk) disable iff (!resetn)
    (rspValid && $past(addr_r) == afecr_pkg::OFS_BURNOUT) |-> rspByte[5:0] == 6'h01;
  endproperty
  a_burn_low: assert property (p_burn_low) else $error("burn-out low bits wrong");

  property p_ro_zero;
    @(posedge core_clk) disable iff (!resetn)
    rspValid |-> !($past(addr_r) == afecr_pkg::OFS_BIAS && rspByte[7:2] != 6'h00) &&
                 !($past(addr_r) == afecr_pkg::OFS_MONITOR && rspByte[6:3] != 4'h0);
  endproperty
  a_ro_zero: assert property (p_ro_zero) else $error("reserved bits not zero");

  property p_write_store;
    @(posedge core_clk) disable iff (!resetn)
    (dataWr && addr_r == afecr_pkg::OFS_GAINRATE) |=> rate_r == $past(cmdByte[3:0]) ##1
      outputRateSelect == $past(rate_r);
  endproperty
  a_write_store: assert property (p_write_store) else $error("rate write lost");

  property p_temp_route;
    @(posedge core_clk) disable iff (!resetn)
    (monSel_r == afecr_pkg::MON_TEMP) |=> monTemperature && !monReference && !monShortMid;
  endproperty
  a_temp_route: assert property (p_temp_route) else $error("temperature routing wrong");

endmodule : afecr_config_regs

// [design/afecr_pkg.sv]
// package: register map, field layout and reset values of the front-end configuration bank
package afecr_pkg;
  // register offsets (4-bit register address)
  localparam logic [3:0] OFS_BURNOUT = 4'h0;
  localparam logic [3:0] OFS_BIAS    = 4'h1;
  localparam logic [3:0] OFS_MONITOR = 4'h2;
  localparam logic [3:0] OFS_GAINRATE = 4'h3;
  localparam logic [3:0] LAST_REG    = 4'h3;

  // reset values of the writable fields
  localparam logic [1:0] RST_BURNOUT_SEL = 2'h0;
  localparam logic [1:0] RST_BIAS_EN     = 2'h0;
  localparam logic [2:0] RST_MON_SEL     = 3'h0;
  localparam logic [2:0] RST_GAIN        = 3'h0;
  localparam logic [3:0] RST_RATE        = 4'h0;

  // fixed read-only patterns
  localparam logic [5:0] BURNOUT_LOW_RO = 6'h01;
  localparam logic [5:0] BIAS_HIGH_RO   = 6'h00;
  localparam logic [3:0] MON_MID_RO     = 4'h0;

  // forced gain code (unity) during reference and temperature monitoring
  localparam logic [2:0] GAIN_UNITY = 3'h0;

  // serial command opcodes (upper nibble) and command encodings
  localparam logic [3:0] OPC_READ  = 4'h2;
  localparam logic [3:0] OPC_WRITE = 4'h4;
  localparam logic [7:0] CMD_NOP   = 8'hFF;

  typedef enum logic [1:0] {
    BURN_OFF,
    BURN_0U5,
    BURN_2U,
    BURN_10U
  } afecr_burn_t;

  typedef enum logic [2:0] {
    MON_NORMAL  = 3'h0,
    MON_OFFSET  = 3'h1,
    MON_REFGAIN = 3'h2,
    MON_TEMP    = 3'h3
  } afecr_mon_t;
endpackage : afecr_pkg

// [test/afecr_host_model.sv]
// host-side command master that drives the configuration bank's byte stream
`timescale 1ns/1ps
module afecr_host_model (
  // clock
  input  wire logic       core_clk,
  // command byte stream
  output logic            cmdValid,
  output logic      [7:0] cmdByte,
  input  wire logic       rspValid,
  input  wire logic [7:0] rspByte
);
  initial begin
    cmdValid = 1'b0;
    cmdByte  = 8'h00;
  end

  task automatic put(input logic [7:0] b);
    @(negedge core_clk);
    cmdValid = 1'b1;
    cmdByte  = b;
  endtask : put

  // released byte shows its inverse so a stale value never passes for a command
  task automatic idle();
    @(negedge core_clk);
    cmdValid = 1'b0;
    cmdByte  = ~cmdByte;
  endtask : idle

  function automatic logic [7:0] legal(input logic [3:0] a, input logic [7:0] d);
    case (a)
      4'h0: legal = {d[7:6], 6'h01};
      4'h1: legal = {6'h00, d[1:0]};
      4'h2: legal = {5'h00, d[2:0]};
      default: legal = {1'b0, d[6:0]};
    endcase
  endfunction : legal

  // raw skips the reserved-bit patterns, only for deliberate misuse
  task automatic wr(input logic [3:0] a, input int n, input logic [7:0] d [4], input bit raw);
    put({4'h4, a});
    put(8'(n - 1));
    for (int i = 0; i < n; i++) put(raw ? d[i] : legal(4'((a + i) % 4), d[i]));
    idle();
  endtask : wr

  task automatic rd(input logic [3:0] a, input int n, output logic [7:0] q [4], output bit ok);
    int t;
    ok = 1'b1;
    put({4'h2, a});
    put(8'(n - 1));
    for (int i = 0; i < n; i++) begin
      put(8'hFF);
      idle();
      t = 0;
      while (rspValid !== 1'b1 && t < 4) begin
        @(negedge core_clk);
        t++;
      end
      if (rspValid !== 1'b1) ok = 1'b0;
      q[i] = rspByte;
    end
  endtask : rd
endmodule : afecr_host_model

// [test/afecr_config_regs_bench.sv]
// self-checking bench for the front-end configuration bank
`timescale 1ns/1ps
module afecr_config_regs_bench;
  logic        core_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        extClockActive = 1'b0;
  logic        cmdValid;
  logic        rspValid;
  logic [7:0]  cmdByte;
  logic [7:0]  rspByte;
  logic [1:0]  burnSel;
  logic        biasN;
  logic        biasP;
  logic        mShort;
  logic        mRef;
  logic        mTemp;
  logic [2:0]  gain;
  logic [3:0]  rate;
  logic [15:0] outsNow;
  int          nMismatch = 0;
  int          cmpCount = 0;

  // fourteen output bits, padded to the checker's width on purpose
  assign outsNow = {2'h0, burnSel, biasN, biasP, mShort, mRef, mTemp, gain, rate};
  always #2.5 core_clk = ~core_clk;

  afecr_config_regs u_dut (.core_clk(core_clk), .resetn(resetn), .cmdValid(cmdValid),
    .cmdByte(cmdByte), .rspValid(rspValid), .rspByte(rspByte),
    .extClockActive(extClockActive), .burnoutCurrentSelect(burnSel), .biasNegative(biasN),
    .biasPositive(biasP), .monShortMid(mShort), .monReference(mRef),
    .monTemperature(mTemp), .amplifierGain(gain), .outputRateSelect(rate));
  afecr_host_model u_host (.core_clk(core_clk), .cmdValid(cmdValid), .cmdByte(cmdByte),
    .rspValid(rspValid), .rspByte(rspByte));

  // ==========================================================
  // helpers
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmpCount, nMismatch);
    if (nMismatch == 0 && cmpCount > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      nMismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // a read that never answers ends the run at once
  task automatic rdChk(input logic [3:0] a, input int n, input logic [7:0] e [4]);
    logic [7:0] q [4];
    bit ok;
    u_host.rd(a, n, q, ok);
    if (!ok) begin
      nMismatch++;
      end_of_test();
    end
    for (int i = 0; i < n; i++) chk("readback", {8'h00, q[i]}, {8'h00, e[i]});
  endtask : rdChk

  task automatic settle();
    repeat (3) @(negedge core_clk);
  endtask : settle

  // ==========================================================
  // scenarios
  task automatic testReset();
    rdChk(4'h0, 4, '{8'h01, 8'h00, 8'h00, 8'h00});
    chk("outputs", outsNow, 16'h0000);
    $display("reset values done");
  endtask : testReset

  task automatic testReadOnly();
    u_host.wr(4'h0, 4, '{8'hFF, 8'hFF, 8'hFF, 8'hFF}, 1'b1);
    rdChk(4'h0, 4, '{8'hC1, 8'h03, 8'h07, 8'h7F});
    u_host.wr(4'h2, 1, '{8'h00, 8'h00, 8'h00, 8'h00}, 1'b0);
    $display("read-only bits done");
  endtask : testReadOnly

  task automatic testBurnout();
    for (int c = 0; c < 4; c++) begin
      u_host.wr(4'h0, 1, '{{2'(c), 6'h01}, 8'h00, 8'h00, 8'h00}, 1'b0);
      settle();
      chk("burnout", {14'h0000, burnSel}, 16'(c));
    end
    $display("burnout codes done");
  endtask : testBurnout

  task automatic testMonitor();
    logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h1, 3'h0};
    logic [2:0] c;
    u_host.wr(4'h1, 3, '{8'h03, 8'h00, 8'h5A, 8'h00}, 1'b0);
    for (int i = 0; i < 6; i++) begin
      c = codes[i];
      u_host.wr(4'h2, 1, '{{5'h00, c}, 8'h00, 8'h00, 8'h00}, 1'b0);
      settle();
      chk("monitor", outsNow, {2'h0, 2'h3, c == 3'h0, c == 3'h0, c == 3'h1, c == 3'h2,
          c == 3'h3, (c >= 3'h2) ? 3'h0 : 3'h5,
          4'hA});
    end
    $display("monitor codes done");
  endtask : testMonitor

  task automatic testClockFlag();
    @(negedge core_clk);
    extClockActive = 1'b1;
    repeat (6) @(negedge core_clk);
    rdChk(4'h2, 1, '{8'h80, 8'h00, 8'h00, 8'h00});
    u_host.wr(4'h2, 1, '{8'h01, 8'h00, 8'h00, 8'h00}, 1'b1);
    rdChk(4'h2, 1, '{8'h81, 8'h00, 8'h00, 8'h00});
    extClockActive = 1'b0;
    repeat (6) @(negedge core_clk);
    u_host.wr(4'h2, 1, '{8'h00, 8'h00, 8'h00, 8'h00}, 1'b0);
    rdChk(4'h2, 1, '{8'h00, 8'h00, 8'h00, 8'h00});
    $display("clock flag done");
  endtask : testClockFlag

  task automatic testWrap();
    rdChk(4'h3, 2, '{8'h5A, 8'hC1, 8'h00, 8'h00});
    rdChk(4'h4, 1, '{8'h00, 8'h00, 8'h00, 8'h00});
    $display("wrap and unmapped done");
  endtask : testWrap

  // every field except the monitor select (left at 0) holds a non-reset value here, so the reset really has work to do
  task automatic testMidReset();
    @(negedge core_clk);
    resetn = 1'b0;
    repeat (2) @(negedge core_clk);
    resetn = 1'b1;
    testReset();
    $display("mid-run reset done");
  endtask : testMidReset

  initial begin
    repeat (2) @(negedge core_clk);
    resetn = 1'b1;
    testReset();
    testReadOnly();
    testBurnout();
    testMonitor();
    testClockFlag();
    testWrap();
    testMidReset();
    end_of_test();
  end
endmodule : afecr_config_regs_bench
